// File: common/stc_pkg.sv
// stc_pkg: constants shared by the sixteen bit timer/counter block
// assumes: one system clock; registers reached over an AXI4-Lite slave

package stc_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CNT_LO = 8'h00;
  localparam logic [7:0] OFF_CNT_HI = 8'h04;
  localparam logic [7:0] OFF_FLAG   = 8'h08;
  localparam logic [7:0] OFF_IRQ_EN = 8'h0C;
  localparam logic [7:0] OFF_CTL    = 8'h10;

  // ---------------------------------------------------------------
  // timer_control fields
  // ---------------------------------------------------------------
  localparam int CTL_RUN   = 0;
  localparam int CTL_SRC   = 1;
  localparam int CTL_BYP   = 2;
  localparam int CTL_OSC   = 3;
  localparam int CTL_PS_LO = 4;
  localparam int CTL_PS_HI = 5;

  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [5:0]  CTL_RST    = 6'h00;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO   = 16'h0000;
  localparam logic [2:0]  PRESC_RST  = 3'h0;
  localparam logic [1:0]  PHASE_RST  = 2'h0;
  // instruction cycle is four system clocks
  localparam logic [1:0]  PHASE_LAST = 2'h3;
  localparam logic [1:0]  RESP_OK    = 2'h0;
  localparam logic [1:0]  RESP_ERR   = 2'h2;

  // terminal prescaler count for ratio 1, 2, 4 or 8
  function automatic logic [2:0] stc_ps_last(input logic [1:0] sel);
    case (sel)
      2'h0:    stc_ps_last = 3'h0;
      2'h1:    stc_ps_last = 3'h1;
      2'h2:    stc_ps_last = 3'h3;
      default: stc_ps_last = 3'h7;
    endcase
  endfunction

endpackage

// File: hw/stc_tick_gen.sv
// stc_tick_gen: count source select, pin synchronisers, prescaler, tick
// assumes: pins are asynchronous; controls come from the same clock domain
`timescale 1ns/1ps

module stc_tick_gen
  import stc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // controls
  input  wire logic       run,
  input  wire logic       src_ext,
  input  wire logic       sync_byp,
  input  wire logic       osc_en,
  input  wire logic [1:0] ps_sel,
  input  wire logic       sleep_mode,
  input  wire logic       presc_clr,
  // pins
  input  wire logic       osc_input_pin,
  input  wire logic       ext_clock_pin,
  // result
  output logic            tick,
  output logic            async_mode
);

  logic [1:0] pin_s1_reg, pin_s2_reg;
  logic       pin_d_reg, pin_d_next;
  logic       armed_reg, armed_next;
  logic [1:0] phase_reg, phase_next;
  logic [2:0] presc_reg, presc_next;
  logic       lvl_reg, lvl_next;
  logic       ps_s1_reg, ps_s2_reg, ps_s3_reg;
  logic       sel_pin, rise, fall, cnt_mode, in_tick, presc_out, sync_pulse;

  // ---------------------------------------------------------------
  // input select and edge detection
  // ---------------------------------------------------------------
  always_comb begin
    sel_pin    = osc_en ? pin_s2_reg[1] : pin_s2_reg[0];
    pin_d_next = sel_pin;
    rise       = sel_pin & ~pin_d_reg;
    fall       = ~sel_pin & pin_d_reg;
    cnt_mode   = run & src_ext;
    // a falling edge must be seen before rising edges count
    armed_next = cnt_mode & (armed_reg | fall);
    phase_next = phase_reg + 2'h1;
    in_tick    = cnt_mode ? (rise & armed_reg)
                          : (run & (phase_reg == PHASE_LAST) & ~sleep_mode);
    // prescaler ahead of the synchroniser; keeps running in sleep only when counting pin edges
    presc_out  = in_tick & (presc_reg == stc_ps_last(ps_sel)) & ~presc_clr;
    presc_next = presc_reg;
    lvl_next   = lvl_reg;
    if (presc_clr) begin
      presc_next = PRESC_RST;
    end else if (in_tick) begin
      presc_next = presc_out ? PRESC_RST : presc_reg + 3'h1;
      lvl_next   = lvl_reg ^ presc_out;
    end
    sync_pulse = ps_s2_reg ^ ps_s3_reg;
    async_mode = src_ext & sync_byp;
    if (!src_ext || sync_byp) begin
      tick = presc_out;
    end else begin
      tick = sync_pulse & ~sleep_mode;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_reg <= 2'h0;
      pin_s2_reg <= 2'h0;
      pin_d_reg  <= 1'b0;
      armed_reg  <= 1'b0;
      phase_reg  <= PHASE_RST;
      presc_reg  <= PRESC_RST;
      lvl_reg    <= 1'b0;
      ps_s1_reg  <= 1'b0;
      ps_s2_reg  <= 1'b0;
      ps_s3_reg  <= 1'b0;
    end else begin
      pin_s1_reg <= {osc_input_pin, ext_clock_pin};
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg  <= pin_d_next;
      armed_reg  <= armed_next;
      phase_reg  <= phase_next;
      presc_reg  <= presc_next;
      lvl_reg    <= lvl_next;
      ps_s1_reg  <= lvl_reg;
      ps_s2_reg  <= ps_s1_reg;
      ps_s3_reg  <= ps_s2_reg;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_arm_first;
    @(posedge clk) disable iff (!rst_b) (cnt_mode && !armed_reg) |-> !in_tick;
  endproperty
  a_arm_first: assert property (p_arm_first) else $error("count edge before arming");

  property p_presc_clr;
    @(posedge clk) disable iff (!rst_b) presc_clr |=> (presc_reg == 3'h0);
  endproperty
  a_presc_clr: assert property (p_presc_clr) else $error("prescaler not cleared");

  property p_sleep_sync;
    @(posedge clk) disable iff (!rst_b) (sleep_mode && src_ext && !sync_byp) |-> !tick;
  endproperty
  a_sleep_sync: assert property (p_sleep_sync) else $error("tick in sleep, sync mode");

  property p_inst_rate;
    @(posedge clk) disable iff (!rst_b) (!src_ext && in_tick) |=> !in_tick [*3];
  endproperty
  a_inst_rate: assert property (p_inst_rate) else $error("timer ticks faster than 1 in 4");

endmodule

// File: hw/stc_timer.sv
// stc_timer: sixteen bit timer/counter with AXI4-Lite register slave
// assumes: one 250 MHz clock; compare triggers and sleep come from
// logic on the same clock; clock pins and port pins are asynchronous
//
// Behaviour
// - sixteen bit count wraps all ones to zero
// - overflow latches flag; irq when enabled
// - source_select picks pin edges or instruction clock
// - run_enable clear holds the count
// - prescale ratio 1, 2, 4, 8; bits 7:6 zero
// - osc_enable turns the crystal oscillator on
// - osc_enable forces pins input, reads zero
// - sync_bypass chooses unsynchronised external counting
// - falling edge needed before first count
// - osc_enable picks oscillator pin, else clock pin
// - prescaler sits ahead of the synchroniser
// - synchronised counter stops in sleep
// - asynchronous counter runs in sleep, wakes
// - no capture/compare time base when asynchronous
// - count byte reads always valid
// - compare trigger clears the count
// - trigger clear never sets overflow flag
// - trigger clear not guaranteed when asynchronous
// - count write beats coincident trigger
// - count bytes untouched by any reset
// - control resets to zero on reset
// - count byte write clears prescaler
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps

module stc_timer
  import stc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // clock pins
  input  wire logic              osc_input_pin,
  input  wire logic              ext_clock_pin,
  // oscillator pin port control
  input  wire logic [1:0]        port_direction,
  input  wire logic [1:0]        port_pin_in,
  output logic [1:0]             port_dir_eff,
  output logic [1:0]             port_pin_rd,
  output logic                   osc_enable_out,
  // system
  input  wire logic              sleep_mode,
  input  wire logic              cmp_trig_a,
  input  wire logic              cmp_trig_b,
  output logic                   overflow_irq,
  output logic                   timebase_valid,
  output logic [15:0]            count_out
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic              aw_hold_reg, aw_hold_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic              w_hold_reg, w_hold_next;
  logic [7:0]        w_data_reg, w_data_next;
  logic              w_strb_reg, w_strb_next;
  logic              bvalid_reg, bvalid_next;
  logic [1:0]        bresp_reg, bresp_next;
  logic              rvalid_reg, rvalid_next;
  logic [7:0]        rdata_reg, rdata_next;
  logic [1:0]        rresp_reg, rresp_next;
  logic              aw_take, w_take, ar_take, do_wr, wr_en;
  logic              cnt_lo_wr, cnt_hi_wr, cnt_wr, ctl_wr, flag_wr, ien_wr;

  logic [5:0]        ctl_reg, ctl_next;
  logic              flag_reg, flag_next;
  logic              ien_reg, ien_next;
  logic [15:0]       count_reg, count_next;
  logic [1:0]        prd_s1_reg, prd_s2_reg;
  logic              tick, async_mode, trig_eff, inc, ovf;

  // true for every mapped register offset
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a == ADDR_W'(OFF_CNT_LO)) || (a == ADDR_W'(OFF_CNT_HI)) ||
              (a == ADDR_W'(OFF_FLAG))   || (a == ADDR_W'(OFF_IRQ_EN)) ||
              (a == ADDR_W'(OFF_CTL));
  endfunction

  // ---------------------------------------------------------------
  // count source and prescaler
  // ---------------------------------------------------------------
  stc_tick_gen u_tick (
    .clk           (clk),
    .rst_b         (rst_b),
    .run           (ctl_reg[CTL_RUN]),
    .src_ext       (ctl_reg[CTL_SRC]),
    .sync_byp      (ctl_reg[CTL_BYP]),
    .osc_en        (ctl_reg[CTL_OSC]),
    .ps_sel        (ctl_reg[CTL_PS_HI:CTL_PS_LO]),
    .sleep_mode    (sleep_mode),
    .presc_clr     (cnt_wr),
    .osc_input_pin (osc_input_pin),
    .ext_clock_pin (ext_clock_pin),
    .tick          (tick),
    .async_mode    (async_mode)
  );

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  always_comb begin
    s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
    s_axi_wready  = ~w_hold_reg & ~bvalid_reg;
    s_axi_arready = ~rvalid_reg;
    aw_take       = s_axi_awvalid & s_axi_awready;
    w_take        = s_axi_wvalid & s_axi_wready;
    ar_take       = s_axi_arvalid & s_axi_arready;
    // the write acts once address and data are both held
    do_wr         = aw_hold_reg & w_hold_reg;
    wr_en         = do_wr & w_strb_reg;
    cnt_lo_wr     = wr_en & (aw_addr_reg == ADDR_W'(OFF_CNT_LO));
    cnt_hi_wr     = wr_en & (aw_addr_reg == ADDR_W'(OFF_CNT_HI));
    cnt_wr        = cnt_lo_wr | cnt_hi_wr;
    flag_wr       = wr_en & (aw_addr_reg == ADDR_W'(OFF_FLAG));
    ien_wr        = wr_en & (aw_addr_reg == ADDR_W'(OFF_IRQ_EN));
    ctl_wr        = wr_en & (aw_addr_reg == ADDR_W'(OFF_CTL));

    aw_hold_next  = aw_hold_reg;
    aw_addr_next  = aw_addr_reg;
    w_hold_next   = w_hold_reg;
    w_data_next   = w_data_reg;
    w_strb_next   = w_strb_reg;
    bvalid_next   = bvalid_reg;
    bresp_next    = bresp_reg;
    if (aw_take) begin
      aw_hold_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (w_take) begin
      w_hold_next = 1'b1;
      w_data_next = s_axi_wdata[7:0];
      w_strb_next = s_axi_wstrb[0];
    end
    if (do_wr) begin
      aw_hold_next = 1'b0;
      w_hold_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = addr_ok(aw_addr_reg) ? RESP_OK : RESP_ERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end

    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (ar_take) begin
      rvalid_next = 1'b1;
      rresp_next  = addr_ok(s_axi_araddr) ? RESP_OK : RESP_ERR;
      // count bytes come straight from the clocked count: never torn
      case (s_axi_araddr)
        ADDR_W'(OFF_CNT_LO): rdata_next = count_reg[7:0];
        ADDR_W'(OFF_CNT_HI): rdata_next = count_reg[15:8];
        ADDR_W'(OFF_FLAG):   rdata_next = {7'h00, flag_reg};
        ADDR_W'(OFF_IRQ_EN): rdata_next = {7'h00, ien_reg};
        ADDR_W'(OFF_CTL):    rdata_next = {2'h0, ctl_reg};
        default:             rdata_next = 8'h00;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_hold_reg  <= 1'b0;
      w_data_reg  <= 8'h00;
      w_strb_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OK;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 8'h00;
      rresp_reg   <= RESP_OK;
    end else begin
      aw_hold_reg <= aw_hold_next;
      aw_addr_reg <= aw_addr_next;
      w_hold_reg  <= w_hold_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // ---------------------------------------------------------------
  // control, flag and enable registers
  // ---------------------------------------------------------------
  always_comb begin
    ctl_next  = ctl_wr ? w_data_reg[5:0] : ctl_reg;
    ien_next  = ien_wr ? w_data_reg[0] : ien_reg;
    flag_next = flag_wr ? w_data_reg[0] : flag_reg;
    // a new overflow wins over a software clear in the same cycle
    if (ovf) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_reg  <= CTL_RST;
      flag_reg <= 1'b0;
      ien_reg  <= 1'b0;
    end else begin
      ctl_reg  <= ctl_next;
      flag_reg <= flag_next;
      ien_reg  <= ien_next;
    end
  end

  // ---------------------------------------------------------------
  // sixteen bit count
  // ---------------------------------------------------------------
  always_comb begin
    // trigger clear is dropped when counting asynchronously
    trig_eff   = (cmp_trig_a | cmp_trig_b) & ~async_mode;
    inc        = tick & ctl_reg[CTL_RUN];
    ovf        = inc & (count_reg == CNT_MAX) & ~cnt_wr & ~trig_eff;
    count_next = count_reg;
    if (cnt_wr) begin
      // a write wins over a coincident trigger and over the increment
      if (cnt_lo_wr) begin
        count_next[7:0] = w_data_reg;
      end
      if (cnt_hi_wr) begin
        count_next[15:8] = w_data_reg;
      end
    end else if (trig_eff) begin
      count_next = CNT_ZERO;
    end else if (inc) begin
      count_next = count_reg + 16'h0001;
    end
  end

  // no reset: the count keeps its value across every reset
  always_ff @(posedge clk) begin
    count_reg <= count_next;
  end

  // ---------------------------------------------------------------
  // port pin read synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prd_s1_reg <= 2'h0;
      prd_s2_reg <= 2'h0;
    end else begin
      prd_s1_reg <= port_pin_in;
      prd_s2_reg <= prd_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_comb begin
    s_axi_bvalid   = bvalid_reg;
    s_axi_bresp    = bresp_reg;
    s_axi_rvalid   = rvalid_reg;
    s_axi_rresp    = rresp_reg;
    s_axi_rdata    = {24'h000000, rdata_reg};
    osc_enable_out = ctl_reg[CTL_OSC];
    // oscillator pins become inputs and read zero
    port_dir_eff   = ctl_reg[CTL_OSC] ? 2'h3 : port_direction;
    port_pin_rd    = ctl_reg[CTL_OSC] ? 2'h0 : prd_s2_reg;
    overflow_irq   = flag_reg & ien_reg;
    timebase_valid = ~async_mode;
    count_out      = count_reg;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_wrap;
    @(posedge clk) disable iff (!rst_b)
      (inc && !cnt_wr && !trig_eff && count_reg == 16'hFFFF) |=> (count_reg == 16'h0000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap to zero");

  property p_ovf_flag;
    @(posedge clk) disable iff (!rst_b)
      ovf |=> flag_reg ##0 (overflow_irq == ien_reg);
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag or irq wrong");

  property p_hold;
    @(posedge clk) disable iff (!rst_b)
      (!ctl_reg[CTL_RUN] && !cnt_wr && !trig_eff) |=> $stable(count_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while stopped");

  property p_trig_clr;
    @(posedge clk) disable iff (!rst_b)
      (trig_eff && !cnt_wr) |=> (count_reg == 16'h0000);
  endproperty
  a_trig_clr: assert property (p_trig_clr) else $error("trigger did not clear count");

  property p_trig_noflag;
    @(posedge clk) disable iff (!rst_b)
      (trig_eff && !flag_reg && !flag_wr) |=> !flag_reg;
  endproperty
  a_trig_noflag: assert property (p_trig_noflag) else $error("trigger set the flag");

  property p_wr_wins;
    @(posedge clk) disable iff (!rst_b)
      (cnt_lo_wr && trig_eff) |=> (count_reg[7:0] == $past(w_data_reg));
  endproperty
  a_wr_wins: assert property (p_wr_wins) else $error("trigger beat count write");

  property p_pins;
    @(posedge clk) disable iff (!rst_b)
      ctl_reg[CTL_OSC] |-> (port_pin_rd == 2'h0 && port_dir_eff == 2'h3);
  endproperty
  a_pins: assert property (p_pins) else $error("oscillator pins not forced to input");

  property p_timebase;
    @(posedge clk) disable iff (!rst_b)
      (ctl_reg[CTL_SRC] && ctl_reg[CTL_BYP]) |-> !timebase_valid;
  endproperty
  a_timebase: assert property (p_timebase) else $error("async time base offered");

  property p_ctl_rd;
    @(posedge clk) disable iff (!rst_b)
      (ar_take && s_axi_araddr == ADDR_W'(OFF_CTL)) |=> (s_axi_rdata[7:6] == 2'h0);
  endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control bits 7:6 not zero");

  property p_cnt_wr;
    @(posedge clk) disable iff (!rst_b)
      cnt_hi_wr |=> (count_reg[15:8] == $past(w_data_reg));
  endproperty
  a_cnt_wr: assert property (p_cnt_wr) else $error("count high byte write lost");

endmodule

// File: dv/stc_clk_src.sv
// stc_clk_src: behavioural external clock source and crystal
// assumes: the bench calls burst; both pins idle low
`timescale 1ns/1ps

module stc_clk_src #(
  parameter int HALF_NS = 21
) (
  // clock pins
  output logic osc_input_pin,
  output logic ext_clock_pin
);
  initial begin
    osc_input_pin = 1'b0;
    ext_clock_pin = 1'b0;
  end
  // n pulses on one pin, still between bursts, unrelated to clk
  task automatic burst(input logic sel, input int n);
    repeat (n) begin
      #HALF_NS;
      {osc_input_pin, ext_clock_pin} = sel ? 2'b10 : 2'b01;
      #HALF_NS;
      {osc_input_pin, ext_clock_pin} = 2'b00;
    end
  endtask
endmodule

// File: dv/tb_stc_timer.sv
// tb_stc_timer: register-level bench of the timer/counter
// assumes: stc_clk_src drives the clock pins
`timescale 1ns/1ps

module tb_stc_timer
  import stc_pkg::*;
();
  logic        clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, sleep, trig_a, trig_b;
  logic        osc_en, irq, tbv, osc_pin, ext_pin, ta, tw;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, pdir, pin, dir_eff, pin_rd, resp;
  logic [15:0] cnt;
  int          n_errors, tests_run, c;

  stc_clk_src u_src (.osc_input_pin(osc_pin), .ext_clock_pin(ext_pin));
  stc_timer #(.ADDR_W(8)) uut (
    .clk(clk), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .osc_input_pin(osc_pin), .ext_clock_pin(ext_pin),
    .port_direction(pdir), .port_pin_in(pin), .port_dir_eff(dir_eff),
    .port_pin_rd(pin_rd), .osc_enable_out(osc_en), .sleep_mode(sleep),
    .cmp_trig_a(trig_a), .cmp_trig_b(trig_b), .overflow_irq(irq),
    .timebase_valid(tbv), .count_out(cnt));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // checks and bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      if (bvalid) break;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    if (k == 64) n_errors++;
    if (k == 64) end_of_test();
    resp = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(negedge clk);
      ta = arvalid && arready;
      if (rvalid) break;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
    if (k == 64) n_errors++;
    if (k == 64) end_of_test();
    rd_v = rdata;
    resp = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask
  // cycles until the count next changes
  task automatic wait_chg(output int n);
    logic [15:0] c0;
    c0 = cnt;
    for (n = 1; n < 400; n++) begin
      @(negedge clk);
      if (cnt !== c0) break;
    end
    if (n == 400) begin
      n_errors++;
      end_of_test();
    end
  endtask
  task automatic wait_cnt(input logic [15:0] e);
    for (int k = 0; k < 400 && cnt !== e; k++) @(negedge clk);
    chk(cnt, e);
    if (cnt !== e) end_of_test();
  endtask

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready, sleep, trig_a, trig_b} = '0;
    {awaddr, araddr, wdata, pdir} = '0;
    wstrb = 4'h1;
    pin = 2'h3;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rd(OFF_CTL); chk(rd_v, 32'h0);
    chk({osc_en, dir_eff, pin_rd}, 5'h03);
    rd(8'h14); chk(rd_v, 32'h0); chk(resp, RESP_ERR);
    wr(8'h14, 32'h1); chk(resp, RESP_ERR);
    wr(OFF_CTL, 32'hFF); rd(OFF_CTL); chk(rd_v, 32'h3F);
    chk(resp, RESP_OK);
    chk({osc_en, tbv}, 2'b10);
    chk({dir_eff, pin_rd}, 4'hC);
    wr(OFF_CTL, 32'h0); wr(OFF_CNT_LO, 32'h0); wr(OFF_CNT_HI, 32'h0);
    for (int ps = 0; ps < 4; ps++) begin
      wr(OFF_CTL, {26'h0, 2'(ps), 4'h1});
      wait_chg(c); wait_chg(c); chk(c, 4 << ps);
    end
    wr(OFF_CTL, 32'h0); c = cnt; repeat (40) @(negedge clk); chk(cnt, c);
    wr(OFF_CNT_LO, 32'hFE); wr(OFF_CNT_HI, 32'hFF); wr(OFF_FLAG, 32'h0);
    wr(OFF_IRQ_EN, 32'h1); chk(irq, 1'b0);
    wr(OFF_CTL, 32'h1); wait_cnt(16'h0);
    rd(OFF_FLAG); chk(rd_v, 32'h1); chk(irq, 1'b1);
    wr(OFF_IRQ_EN, 32'h0); chk(irq, 1'b0);
    for (int i = 0; i < 2; i++) begin
      wr(OFF_CTL, 32'h0); wr(OFF_CNT_HI, 32'h12); wr(OFF_FLAG, 32'h0);
      wr(OFF_CTL, 32'h1);
      @(posedge clk); {trig_b, trig_a} <= 2'(1 << i);
      @(posedge clk); {trig_b, trig_a} <= 2'b00;
      @(negedge clk); chk(cnt, 32'h0);
      rd(OFF_FLAG); chk(rd_v, 32'h0);
    end
    wr(OFF_CTL, 32'h0); wr(OFF_CNT_LO, 32'h0); wr(OFF_CNT_HI, 32'h0);
    wr(OFF_CTL, 32'h7); u_src.burst(1'b0, 5); wait_cnt(16'h4);
    wr(OFF_CTL, 32'h0); wr(OFF_CTL, 32'hF); repeat (100) @(posedge clk);
    u_src.burst(1'b0, 3); repeat (20) @(negedge clk); chk(cnt, 32'h4);
    u_src.burst(1'b1, 3); wait_cnt(16'h6);
    chk({dir_eff, pin_rd, tbv}, 5'h18);
    @(posedge clk); sleep <= 1'b1; u_src.burst(1'b1, 3); wait_cnt(16'h9);
    wr(OFF_CTL, 32'h0); wr(OFF_CTL, 32'hB);
    u_src.burst(1'b1, 4); repeat (40) @(negedge clk); chk(cnt, 32'h9);
    chk(tbv, 1'b1);
    @(posedge clk); sleep <= 1'b0;
    u_src.burst(1'b1, 2); wait_cnt(16'hB);
    // stopped counter read high, low, high
    wr(OFF_CTL, 32'h0);
    rd(OFF_CNT_HI); chk(rd_v, 32'h0);
    rd(OFF_CNT_LO); chk(rd_v, 32'hB);
    rd(OFF_CNT_HI); chk(rd_v, 32'h0);
    wr(OFF_CTL, 32'h3F); @(posedge clk); rst_b <= 1'b0;
    repeat (2) @(posedge clk); rst_b <= 1'b1;
    @(negedge clk); chk(cnt, 32'hB);
    rd(OFF_CTL); chk(rd_v, 32'h0);
    // lane 0 strobe low: the write is answered but changes nothing
    wstrb <= 4'h0; wr(OFF_CTL, 32'h1); rd(OFF_CTL); chk(rd_v, 32'h0);
    end_of_test();
  end
endmodule
